// ---- logic/srs_pkg.sv ----
// Shared constants, types and helpers for the reset sequencer.
package srs_pkg;

  // Clock rate of the free-running timebase.
  localparam int CLK_HZ = 25_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;

  // Reset timeout: typical figure is used, the minimum is for reference.
  localparam int TIMEOUT_TYP_MS = 210;
  localparam int TIMEOUT_MIN_MS = 140;
  // Debounce of the immediate input on its falling side.
  localparam int IMM_DEBOUNCE_MS = 210;
  // Debounce of hold-button releases.
  localparam int REL_DEBOUNCE_MS = 20;

  // Selectable button hold times.
  localparam int HOLD_10P08_MS = 10080;
  localparam int HOLD_6P72_MS = 6720;
  localparam int HOLD_3P36_MS = 3360;
  localparam int HOLD_1P68_MS = 1680;

  typedef enum logic [1:0] {
    SRS_HOLD_10P08 = 2'h0,
    SRS_HOLD_6P72 = 2'h1,
    SRS_HOLD_3P36 = 2'h2,
    SRS_HOLD_1P68 = 2'h3
  } srs_hold_sel_t;

  typedef enum logic [2:0] {
    HOLD_IDLE = 3'h1,
    HOLD_TIMING = 3'h2,
    HOLD_DONE = 3'h4
  } srs_hold_st_t;

  // Bit positions in the synchroniser vector.
  localparam int IN_MAIN = 0;
  localparam int IN_AUX = 1;
  localparam int IN_BTN_A = 2;
  localparam int IN_BTN_B = 3;
  localparam int IN_W = 4;

  function automatic int ms_cycles(input int ms);
    return ms * CYC_PER_MS;
  endfunction

  function automatic int hold_ms(input srs_hold_sel_t sel);
    case (sel)
      SRS_HOLD_10P08: return HOLD_10P08_MS;
      SRS_HOLD_6P72: return HOLD_6P72_MS;
      SRS_HOLD_3P36: return HOLD_3P36_MS;
      default: return HOLD_1P68_MS;
    endcase
  endfunction

  localparam int TIMEOUT_CYCLES = ms_cycles(TIMEOUT_TYP_MS);
  localparam int IMM_DB_CYCLES = ms_cycles(IMM_DEBOUNCE_MS);
  localparam int REL_DB_CYCLES = ms_cycles(REL_DEBOUNCE_MS);

endpackage

// ---- logic/srs_supervisor_reset_sequencer.sv ----
// Reset sequencer: supply, hold-button and immediate-input reset timing.
//
// Operation
// - A low main or auxiliary supply flag drives the reset output low.
// - After all supplies are good, reset stays low a full timeout, then rises.
// - The power-up timeout is 210 ms, never below the 140 ms minimum.
// - A hold button asserts reset only after staying low the whole hold time.
// - The hold time is a build choice of 10.08, 6.72, 3.36 or 1.68 seconds.
// - A completed hold gives one low pulse lasting the reset timeout.
// - With two hold buttons the hold timer runs only while both are low.
// - One pulse per hold; another needs a release and a new full hold.
// - Releases of hold buttons are debounced so bounce changes nothing.
// - A release before the hold time ends aborts it; the next low restarts.
// - A rising edge on the immediate input asserts reset and starts a timeout.
// - A rising edge during a running timeout restarts it with reset held.
// - Reset is released only after a full timeout with no new rising edge.
// - Falling edges of the immediate input are debounced for 210 ms.
`timescale 1ns/100ps
module srs_supervisor_reset_sequencer
  import srs_pkg::*;
#(
  parameter srs_hold_sel_t HOLD_SEL = SRS_HOLD_6P72, // Hold time choice.
  parameter bit DUAL_HOLD = 1'b1, // 1: two hold buttons, 0: immediate input.
  parameter bit HAS_AUX = 1'b1, // Auxiliary supply flag is monitored.
  parameter int CNT_W = 28, // Width of every interval counter.
  parameter int TIMEOUT_CYC = TIMEOUT_CYCLES, // Reset timeout length.
  parameter int HOLD_CYC = ms_cycles(hold_ms(HOLD_SEL)), // Hold length.
  parameter int REL_DB_CYC = REL_DB_CYCLES, // Release debounce length.
  parameter int IMM_DB_CYC = IMM_DB_CYCLES // Immediate fall debounce.
)(
  input wire logic clk, // Free-running 25 MHz clock.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic main_supply_ok, // Main supply above threshold.
  input wire logic aux_supply_sense, // Auxiliary input above threshold.
  input wire logic hold_button_a_n, // First hold button, low when pressed.
  input wire logic second_button_in, // Second hold button or immediate input.
  output logic reset_out_n // Reset to the processor, active low.
);

  localparam logic [CNT_W-1:0] TO_LAST = CNT_W'(TIMEOUT_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] REL_LAST = CNT_W'(REL_DB_CYC - 1);
  localparam logic [CNT_W-1:0] IDB_LAST = CNT_W'(IMM_DB_CYC - 1);
  // Buttons idle released; the immediate input idles low.
  localparam logic [IN_W-1:0] SYNC_RST = {DUAL_HOLD, 1'b1, 1'b0, 1'b0};

  if (TIMEOUT_CYC < 1 || HOLD_CYC < 1 || REL_DB_CYC < 1 || IMM_DB_CYC < 1)
  begin : g_bad_count
    $error("All interval counts must be at least one cycle.");
  end
  if (CNT_W < 1 || CNT_W > 31 || TIMEOUT_CYC >= (1 << CNT_W) ||
      HOLD_CYC >= (1 << CNT_W) || IMM_DB_CYC >= (1 << CNT_W) ||
      REL_DB_CYC >= (1 << CNT_W))
  begin : g_bad_width
    $error("Counter width too small for the configured counts.");
  end

  function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] c);
    return c + CNT_W'(1);
  endfunction

  // Two-stage synchroniser for every pin input.
  logic [IN_W-1:0] sync1;
  logic [IN_W-1:0] sync2;
  logic [IN_W-1:0] pins;

  always_comb
  begin
    pins = {second_button_in, hold_button_a_n, aux_supply_sense,
            main_supply_ok};
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sync1 <= SYNC_RST;
      sync2 <= SYNC_RST;
    end
    else
    begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  logic supplies_ok;
  logic imm_raw;

  always_comb
  begin
    supplies_ok = sync2[IN_MAIN] & (sync2[IN_AUX] | !HAS_AUX);
    imm_raw = !DUAL_HOLD & sync2[IN_BTN_B];
  end

  // Power-up timeout.
  logic por_hold;
  logic next_por_hold;
  logic [CNT_W-1:0] por_cnt;
  logic [CNT_W-1:0] next_por_cnt;

  always_comb
  begin
    next_por_hold = por_hold;
    next_por_cnt = por_cnt;
    if (!supplies_ok)
    begin
      next_por_hold = 1'b1;
      next_por_cnt = '0;
    end
    else if (por_hold)
    begin
      if (por_cnt == TO_LAST)
        next_por_hold = 1'b0;
      else
        next_por_cnt = step(por_cnt);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      por_hold <= 1'b1;
      por_cnt <= '0;
    end
    else
    begin
      por_hold <= next_por_hold;
      por_cnt <= next_por_cnt;
    end
  end

  // Release debounce: a button reads pressed until it stays high a while.
  logic [1:0] db_low;
  logic [1:0] next_db_low;
  logic [CNT_W-1:0] rel_cnt [2];
  logic [CNT_W-1:0] next_rel_cnt [2];
  logic [1:0] btn_raw_n;

  always_comb
  begin
    btn_raw_n = {sync2[IN_BTN_B] | !DUAL_HOLD, sync2[IN_BTN_A]};
    for (int i = 0; i < 2; i++)
    begin
      next_db_low[i] = db_low[i];
      next_rel_cnt[i] = rel_cnt[i];
      if (!btn_raw_n[i])
      begin
        next_db_low[i] = 1'b1;
        next_rel_cnt[i] = '0;
      end
      else if (db_low[i])
      begin
        if (rel_cnt[i] == REL_LAST)
          next_db_low[i] = 1'b0;
        else
          next_rel_cnt[i] = step(rel_cnt[i]);
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      db_low <= '0;
      rel_cnt[0] <= '0;
      rel_cnt[1] <= '0;
    end
    else
    begin
      db_low <= next_db_low;
      rel_cnt[0] <= next_rel_cnt[0];
      rel_cnt[1] <= next_rel_cnt[1];
    end
  end

  // Hold timer state machine.
  srs_hold_st_t hold_st;
  srs_hold_st_t next_hold_st;
  logic [CNT_W-1:0] hold_cnt;
  logic [CNT_W-1:0] next_hold_cnt;
  logic hold_active;
  logic hold_fire;

  always_comb
  begin
    hold_active = db_low[0] & (db_low[1] | !DUAL_HOLD);
    next_hold_st = hold_st;
    next_hold_cnt = hold_cnt;
    hold_fire = 1'b0;
    unique case (hold_st)
      HOLD_IDLE:
        if (hold_active)
        begin
          next_hold_st = HOLD_TIMING;
          next_hold_cnt = '0;
        end
      HOLD_TIMING:
        if (!hold_active)
          next_hold_st = HOLD_IDLE;
        else if (hold_cnt == HOLD_LAST)
        begin
          next_hold_st = HOLD_DONE;
          hold_fire = 1'b1;
        end
        else
          next_hold_cnt = step(hold_cnt);
      HOLD_DONE:
        if (!hold_active)
          next_hold_st = HOLD_IDLE;
      default:
        next_hold_st = HOLD_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      hold_st <= HOLD_IDLE;
      hold_cnt <= '0;
    end
    else
    begin
      hold_st <= next_hold_st;
      hold_cnt <= next_hold_cnt;
    end
  end

  // One-shot pulse after a completed hold.
  logic btn_pulse;
  logic next_btn_pulse;
  logic [CNT_W-1:0] pulse_cnt;
  logic [CNT_W-1:0] next_pulse_cnt;

  always_comb
  begin
    next_btn_pulse = btn_pulse;
    next_pulse_cnt = pulse_cnt;
    if (hold_fire)
    begin
      next_btn_pulse = 1'b1;
      next_pulse_cnt = '0;
    end
    else if (btn_pulse)
    begin
      if (pulse_cnt == TO_LAST)
        next_btn_pulse = 1'b0;
      else
        next_pulse_cnt = step(pulse_cnt);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      btn_pulse <= 1'b0;
      pulse_cnt <= '0;
    end
    else
    begin
      btn_pulse <= next_btn_pulse;
      pulse_cnt <= next_pulse_cnt;
    end
  end

  // Immediate input: edge trigger, restartable timeout, fall debounce.
  logic imm_prev;
  logic imm_db;
  logic next_imm_db;
  logic [CNT_W-1:0] imm_dcnt;
  logic [CNT_W-1:0] next_imm_dcnt;
  logic imm_active;
  logic next_imm_active;
  logic [CNT_W-1:0] imm_cnt;
  logic [CNT_W-1:0] next_imm_cnt;
  logic imm_rise;
  logic imm_start;

  always_comb
  begin
    imm_rise = imm_raw & !imm_prev;
    // A fresh trigger needs a debounced low; bounce may only restart.
    imm_start = imm_rise & (imm_active | !imm_db);
    next_imm_db = imm_db;
    next_imm_dcnt = imm_dcnt;
    if (imm_raw)
    begin
      next_imm_db = 1'b1;
      next_imm_dcnt = '0;
    end
    else if (imm_db)
    begin
      if (imm_dcnt == IDB_LAST)
        next_imm_db = 1'b0;
      else
        next_imm_dcnt = step(imm_dcnt);
    end
    next_imm_active = imm_active;
    next_imm_cnt = imm_cnt;
    if (imm_start)
    begin
      next_imm_active = 1'b1;
      next_imm_cnt = '0;
    end
    else if (imm_active)
    begin
      if (imm_cnt == TO_LAST)
        next_imm_active = 1'b0;
      else
        next_imm_cnt = step(imm_cnt);
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      imm_prev <= 1'b0;
      imm_db <= 1'b0;
      imm_dcnt <= '0;
      imm_active <= 1'b0;
      imm_cnt <= '0;
    end
    else
    begin
      imm_prev <= imm_raw;
      imm_db <= next_imm_db;
      imm_dcnt <= next_imm_dcnt;
      imm_active <= next_imm_active;
      imm_cnt <= next_imm_cnt;
    end
  end

  // Output register combines every reset source.
  logic next_reset_out_n;

  always_comb
  begin
    next_reset_out_n = !(!supplies_ok | por_hold | btn_pulse |
                         imm_active);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      reset_out_n <= 1'b0;
    else
      reset_out_n <= next_reset_out_n;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_undervolt;
    !supplies_ok |=> !reset_out_n ##1 !reset_out_n;
  endproperty
  a_undervolt: assert property (p_undervolt)
    else $error("Reset not held low during undervoltage.");

  property p_por_hold;
    supplies_ok && por_hold && por_cnt != TO_LAST |=> por_hold;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("Power-up timeout ended early.");

  property p_por_end;
    supplies_ok && por_hold && por_cnt == TO_LAST |=> !por_hold;
  endproperty
  a_por_end: assert property (p_por_end)
    else $error("Power-up timeout did not end on time.");

  property p_hold_fire;
    hold_st == HOLD_TIMING && hold_active && hold_cnt == HOLD_LAST
      |=> btn_pulse && pulse_cnt == '0 ##1 !reset_out_n;
  endproperty
  a_hold_fire: assert property (p_hold_fire)
    else $error("Completed hold did not start the reset pulse.");

  property p_no_early;
    $rose(btn_pulse) |-> $past(hold_st) == HOLD_TIMING;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("Button pulse without a completed hold.");

  property p_pulse_len;
    btn_pulse && pulse_cnt != TO_LAST |=> btn_pulse;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("Button reset pulse shorter than the timeout.");

  property p_dual;
    DUAL_HOLD && hold_st == HOLD_TIMING && !(db_low[0] && db_low[1])
      |=> hold_st == HOLD_IDLE;
  endproperty
  a_dual: assert property (p_dual)
    else $error("Hold timer ran without both buttons low.");

  property p_once;
    hold_st == HOLD_DONE && hold_active |=> hold_st == HOLD_DONE;
  endproperty
  a_once: assert property (p_once)
    else $error("Second pulse without a release.");

  property p_rel_db;
    db_low[0] && rel_cnt[0] != REL_LAST |=> db_low[0];
  endproperty
  a_rel_db: assert property (p_rel_db)
    else $error("Button release not debounced.");

  property p_abort;
    hold_st == HOLD_TIMING && !hold_active
      |=> hold_st == HOLD_IDLE && !hold_fire;
  endproperty
  a_abort: assert property (p_abort)
    else $error("Early release did not abort the hold.");

  property p_imm_start;
    imm_start |=> imm_active && imm_cnt == '0 ##1 !reset_out_n;
  endproperty
  a_imm_start: assert property (p_imm_start)
    else $error("Immediate edge did not assert reset.");

  property p_imm_restart;
    imm_active && imm_rise |=> imm_active && imm_cnt == '0;
  endproperty
  a_imm_restart: assert property (p_imm_restart)
    else $error("Edge during timeout did not restart it.");

  property p_imm_end;
    imm_active && !imm_rise && imm_cnt == TO_LAST |=> !imm_active;
  endproperty
  a_imm_end: assert property (p_imm_end)
    else $error("Immediate timeout not released on time.");

  property p_imm_db;
    !imm_raw && imm_db && imm_dcnt != IDB_LAST |=> imm_db;
  endproperty
  a_imm_db: assert property (p_imm_db)
    else $error("Immediate input fall not debounced.");

endmodule // srs_supervisor_reset_sequencer

// ---- bench/srs_proc_model.sv ----
// Processor reset input model that records the width of each reset pulse.
`timescale 1ns/100ps
module srs_proc_model (
  input wire logic clk, // Free-running system clock.
  input wire logic reset_in_n // Reset seen by the processor, active low.
);
  int widths[$];
  int run = 0;

  // A pulse is logged once the reset input has risen again.
  always @(posedge clk)
  begin
    if (reset_in_n === 1'b0)
    begin
      run <= run + 1;
    end
    else
    begin
      if (run != 0)
      begin
        widths.push_back(run);
      end
      run <= 0;
    end
  end
endmodule // srs_proc_model

// ---- bench/tb.sv ----
// Self-checking bench for the reset sequencer in dual and immediate modes.
`timescale 1ns/100ps
module tb;
  import srs_pkg::*;
  localparam int TO = 20;
  localparam int HC = 50;
  localparam int RD = 5;
  localparam int ID = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic main_ok = 1'b1;
  logic aux_ok = 1'b1;
  logic btn_a_n = 1'b1;
  logic btn_b_n = 1'b1;
  logic imm = 1'b0;
  logic rst_d_n;
  logic rst_i_n;
  int error_cnt = 0;
  int tests_run = 0;
  int exp_d[$];
  int exp_i[$];
  logic [31:0] rng = 32'h0000c7e7;

  srs_supervisor_reset_sequencer #(.DUAL_HOLD(1'b1), .TIMEOUT_CYC(TO),
    .HOLD_CYC(HC), .REL_DB_CYC(RD), .IMM_DB_CYC(ID)) u_dut (
    .clk(clk), .reset(reset), .main_supply_ok(main_ok),
    .aux_supply_sense(aux_ok), .hold_button_a_n(btn_a_n),
    .second_button_in(btn_b_n), .reset_out_n(rst_d_n));
  srs_supervisor_reset_sequencer #(.DUAL_HOLD(1'b0), .TIMEOUT_CYC(TO),
    .HOLD_CYC(HC), .REL_DB_CYC(RD), .IMM_DB_CYC(ID)) u_dut_imm (
    .clk(clk), .reset(reset), .main_supply_ok(main_ok),
    .aux_supply_sense(aux_ok), .hold_button_a_n(btn_a_n),
    .second_button_in(imm), .reset_out_n(rst_i_n));
  srs_proc_model mon_d (.clk(clk), .reset_in_n(rst_d_n));
  srs_proc_model mon_i (.clk(clk), .reset_in_n(rst_i_n));

  always #20 clk = ~clk;

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Counts falling edges until the chosen output reaches a level.
  task automatic wait_lvl(input bit sel, input logic lvl, input int bound,
    output int n);
    n = 0;
    while (((sel ? rst_i_n : rst_d_n) !== lvl) && n < bound)
    begin
      @(negedge clk);
      n++;
    end
    // The level itself decides: reaching it on the last allowed edge is fine.
    if ((sel ? rst_i_n : rst_d_n) !== lvl)
    begin
      error_cnt++;
      $display("ERROR at %0t: output level wait timed out", $time);
      finish_test();
    end
  endtask

  // Compares logged pulse widths with the bench's expected widths.
  task automatic cmp_q(ref int got[$], ref int exp[$]);
    check(got.size(), exp.size());
    foreach (exp[k])
    begin
      if (k < got.size())
      begin
        check(got[k] >= exp[k] && got[k] <= exp[k] + 2, 1);
      end
    end
    got.delete();
    exp.delete();
  endtask

  task automatic end_test(input string name);
    cmp_q(mon_d.widths, exp_d);
    cmp_q(mon_i.widths, exp_i);
    $display("test %s done", name);
  endtask

  initial
  begin
    int n;
    int m;
    int d;
    cyc(4);
    reset = 1'b0;
    wait_lvl(0, 1'b1, TO + 10, n);
    check(n >= TO && n <= TO + 5, 1);
    wait_lvl(1, 1'b1, 10, n);
    // The monitors log a pulse one edge after it ends; let that happen first.
    cyc(2);
    mon_d.widths.delete();
    mon_i.widths.delete();
    $display("test power_up done");
    // Brownout on each supply flag, random length.
    for (int s = 0; s < 2; s++)
    begin
      d = 2 + int'(rnd() % 32'h7);
      main_ok = (s != 0);
      aux_ok = (s == 0);
      cyc(4);
      check(rst_d_n, 1'b0);
      check(rst_i_n, 1'b0);
      cyc(d);
      main_ok = 1'b1;
      aux_ok = 1'b1;
      exp_d.push_back(d + 4 + TO);
      exp_i.push_back(d + 4 + TO);
      cyc(TO + 8);
    end
    end_test("supply");
    // Short holds: release before the end, then restart from zero.
    btn_a_n = 1'b0;
    btn_b_n = 1'b0;
    cyc(HC / 2);
    btn_a_n = 1'b1;
    btn_b_n = 1'b1;
    cyc(RD + 3);
    btn_a_n = 1'b0;
    btn_b_n = 1'b0;
    cyc(HC / 2 + 10);
    btn_a_n = 1'b1;
    btn_b_n = 1'b1;
    cyc(RD + 5);
    end_test("short_hold");
    // One button, then both: single-input part fires on one, dual part only on both.
    btn_a_n = 1'b0;
    cyc(HC + 20);
    check(rst_d_n, 1'b1);
    exp_i.push_back(TO);
    btn_b_n = 1'b0;
    cyc(HC / 2);
    btn_b_n = 1'b1;
    cyc(2);
    btn_b_n = 1'b0;
    wait_lvl(0, 1'b0, HC, n);
    check(HC / 2 + 2 + n >= HC && HC / 2 + 2 + n <= HC + 8, 1);
    exp_d.push_back(TO);
    cyc(3 * HC);
    btn_a_n = 1'b1;
    btn_b_n = 1'b1;
    cyc(RD + 5);
    btn_a_n = 1'b0;
    btn_b_n = 1'b0;
    wait_lvl(0, 1'b0, HC + 12, n);
    check(n >= HC - RD - 5, 1);
    exp_d.push_back(TO);
    exp_i.push_back(TO);
    cyc(TO + 5);
    btn_a_n = 1'b1;
    btn_b_n = 1'b1;
    cyc(TO + 5);
    end_test("hold_pulse");
    // Immediate input: rising edges, restart and falling debounce.
    imm = 1'b1;
    wait_lvl(1, 1'b0, 6, n);
    check(n <= 4, 1);
    cyc(8);
    imm = 1'b0;
    cyc(2);
    imm = 1'b1;
    wait_lvl(1, 1'b1, TO + 10, m);
    check(m >= TO && m <= TO + 5, 1);
    exp_i.push_back(10 + TO + 4);
    imm = 1'b0;
    cyc(5);
    imm = 1'b1;
    cyc(10);
    check(rst_i_n, 1'b1);
    imm = 1'b0;
    cyc(ID + 6);
    imm = 1'b1;
    wait_lvl(1, 1'b0, 6, n);
    check(n <= 4, 1);
    exp_i.push_back(TO);
    cyc(TO + 8);
    end_test("immediate");
    finish_test();
  end
endmodule // tb
